// *** verilog/rprs_pkg.sv ***
// constants, states and lookup table of the supply and reset sequencer
// assumes a single 250 MHz system clock that paces every timer
package rprs_pkg;
    // ***********************************************
    // clock and time bases
    // ***********************************************
    localparam logic [35:0] CLK_HZ = 36'd250000000;
    localparam logic [35:0] DEBOUNCE_MS = 36'd250;
    localparam logic [35:0] HOLD_MS = 36'd250;
    localparam logic [35:0] RECOVERY_MS = 36'd250;
    localparam logic [35:0] FIRST_CONV_S = 36'd2;
    localparam logic [35:0] CONV_PERIOD_S = 36'd64;
    localparam logic [35:0] MS_DIV = 36'd1000;
    localparam logic [35:0] DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / MS_DIV;
    localparam logic [35:0] HOLD_CYC = HOLD_MS * CLK_HZ / MS_DIV;
    localparam logic [35:0] RECOVERY_CYC = RECOVERY_MS * CLK_HZ / MS_DIV;
    localparam logic [35:0] FIRST_CONV_CYC = FIRST_CONV_S * CLK_HZ;
    localparam logic [35:0] CONV_PERIOD_CYC = CONV_PERIOD_S * CLK_HZ;
    localparam logic [35:0] CNT_ZERO = 36'h000000000;
    localparam logic [35:0] CNT_ONE = 36'h000000001;

    // ***********************************************
    // calendar start values, bcd
    // ***********************************************
    localparam logic [7:0] INIT_SECONDS = 8'h00;
    localparam logic [7:0] INIT_MINUTES = 8'h00;
    localparam logic [7:0] INIT_HOURS = 8'h00;
    localparam logic [7:0] INIT_WEEKDAY = 8'h01;
    localparam logic [7:0] INIT_DATE = 8'h01;
    localparam logic [7:0] INIT_MONTH = 8'h01;
    localparam logic [7:0] INIT_YEAR = 8'h00;

    // ***********************************************
    // load setting lookup, indexed by temperature msbs
    // ***********************************************
    localparam int TEMP_W = 10;
    localparam int LUT_IDX_HI = 9;
    localparam int LUT_IDX_LO = 6;
    localparam logic [7:0] LUT [16] = '{
        8'h20, 8'h38, 8'h4C, 8'h5C, 8'h68, 8'h72, 8'h78, 8'h7C,
        8'h7C, 8'h78, 8'h72, 8'h68, 8'h5C, 8'h4C, 8'h38, 8'h20
    };
    localparam logic signed [9:0] CAP_MIN = 10'sh000;
    localparam logic signed [9:0] CAP_MAX = 10'sh0FF;
    localparam logic [7:0] CAP_RESET = 8'h00;
    // synchronisers start with supplies absent and the reset wire released
    localparam logic [4:0] SYNC_RESET = 5'h08;

    typedef enum logic [2:0] {
        RPRS_POWER_FAIL,
        RPRS_RECOVER,
        RPRS_IDLE,
        RPRS_DEBOUNCE,
        RPRS_WAIT_RELEASE,
        RPRS_HOLD
    } rprs_state_t;
endpackage

// *** verilog/rprs_top.sv ***
// supply selection, reset pin sequencing, oscillator gating and conversion scheduling
// assumes comparator and pin inputs may be asynchronous; the conversion engine reports on TEMP_DONE
`timescale 1ns/1ns

module rprs_top
    import rprs_pkg::*;
#(
    parameter logic [35:0] DEBOUNCE_CNT = DEBOUNCE_CYC,
    parameter logic [35:0] HOLD_CNT = HOLD_CYC,
    parameter logic [35:0] RECOVERY_CNT = RECOVERY_CYC,
    parameter logic [35:0] FIRST_CONV_CNT = FIRST_CONV_CYC,
    parameter logic [35:0] CONV_PERIOD_CNT = CONV_PERIOD_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic VCC_ABOVE_PF,
    input wire logic VCC_ABOVE_BAT,
    input wire logic BAT_PRESENT,
    input wire logic RSTN_PIN_IN,
    output logic RSTN_PIN_OUT,
    output logic RSTN_PIN_OE,
    input wire logic OSC_DISABLE,
    input wire logic I2C_ADDR_VALID,
    input wire logic OSC_CLK_IN,
    input wire logic CLKOUT_EN,
    output logic OSC_CLK_OUT,
    output logic OSC_CLK_OE,
    output logic OSC_RUN,
    output logic SUPPLY_BAT,
    output logic CONV_START,
    input wire logic TEMP_DONE,
    input wire logic TEMP_USER,
    input wire logic [TEMP_W-1:0] TEMP_VALUE,
    input wire logic signed [7:0] AGING_OFFSET,
    output logic [7:0] CAP_SEL,
    output logic CAL_LOAD,
    output logic [7:0] CAL_SECONDS,
    output logic [7:0] CAL_MINUTES,
    output logic [7:0] CAL_HOURS,
    output logic [7:0] CAL_WEEKDAY,
    output logic [7:0] CAL_DATE,
    output logic [7:0] CAL_MONTH,
    output logic [7:0] CAL_YEAR
);
    // ***********************************************
    // input synchronisers
    // ***********************************************
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic vcc_ok;
    logic vcc_gt_bat;
    logic bat_ok;
    logic pin_level;
    logic osc_level;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync_a <= SYNC_RESET;
            sync_b <= SYNC_RESET;
        end else begin
            sync_a <= {OSC_CLK_IN, RSTN_PIN_IN, BAT_PRESENT, VCC_ABOVE_BAT, VCC_ABOVE_PF};
            sync_b <= sync_a;
        end
    end

    assign vcc_ok = sync_b[0];
    assign vcc_gt_bat = sync_b[1];
    assign bat_ok = sync_b[2];
    assign pin_level = sync_b[3];
    assign osc_level = sync_b[4];

    logic vcc_prev;
    logic bat_prev;
    logic pin_prev;
    logic vcc_rise;
    logic pin_fall;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            vcc_prev <= 1'b0;
            bat_prev <= 1'b0;
            pin_prev <= 1'b1;
        end else begin
            vcc_prev <= vcc_ok;
            bat_prev <= bat_ok;
            pin_prev <= pin_level;
        end
    end

    assign vcc_rise = vcc_ok & ~vcc_prev;
    assign pin_fall = pin_prev & ~pin_level;

    // ***********************************************
    // supply selection and oscillator gating
    // ***********************************************
    logic osc_started;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SUPPLY_BAT <= 1'b0;
        end else begin
            SUPPLY_BAT <= ~vcc_ok & ~vcc_gt_bat;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            osc_started <= 1'b0;
        end else if (~vcc_ok & ~bat_ok) begin
            osc_started <= 1'b0;
        end else if (bat_ok & ~bat_prev & ~osc_started & ~vcc_ok) begin
            osc_started <= 1'b0;
        end else if (vcc_ok | I2C_ADDR_VALID) begin
            osc_started <= 1'b1;
        end
    end

    // independent of the reset pin state
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            OSC_RUN <= 1'b0;
        end else begin
            OSC_RUN <= osc_started & ~OSC_DISABLE;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            OSC_CLK_OE <= 1'b0;
        end else begin
            OSC_CLK_OE <= OSC_RUN & CLKOUT_EN & ~osc_level;
        end
    end

    assign OSC_CLK_OUT = 1'b0;

    // ***********************************************
    // reset pin sequencer
    // ***********************************************
    rprs_state_t state;
    logic [35:0] rst_cnt;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state <= RPRS_POWER_FAIL;
            rst_cnt <= CNT_ZERO;
        end else if (~vcc_ok) begin
            state <= RPRS_POWER_FAIL;
            rst_cnt <= CNT_ZERO;
        end else begin
            rst_cnt <= rst_cnt + CNT_ONE;
            unique case (state)
                RPRS_POWER_FAIL: begin
                    rst_cnt <= CNT_ZERO;
                    if (OSC_RUN) begin
                        state <= RPRS_RECOVER;
                    end else begin
                        state <= RPRS_IDLE;
                    end
                end
                RPRS_RECOVER: begin
                    if (OSC_DISABLE) begin
                        state <= RPRS_IDLE;
                    end else if (rst_cnt >= RECOVERY_CNT - CNT_ONE) begin
                        state <= RPRS_IDLE;
                    end
                end
                RPRS_IDLE: begin
                    rst_cnt <= CNT_ZERO;
                    if (pin_fall) begin
                        state <= RPRS_DEBOUNCE;
                    end
                end
                RPRS_DEBOUNCE: begin
                    if (rst_cnt >= DEBOUNCE_CNT - CNT_ONE) begin
                        state <= RPRS_WAIT_RELEASE;
                    end
                end
                RPRS_WAIT_RELEASE: begin
                    rst_cnt <= CNT_ZERO;
                    if (pin_level) begin
                        state <= RPRS_HOLD;
                    end
                end
                RPRS_HOLD: begin
                    if (rst_cnt >= HOLD_CNT - CNT_ONE) begin
                        state <= RPRS_IDLE;
                    end
                end
            endcase
        end
    end

    // open drain: drive low only, pull-up does the release
    assign RSTN_PIN_OUT = 1'b0;
    assign RSTN_PIN_OE = (state != RPRS_IDLE) && (state != RPRS_WAIT_RELEASE);

    // ***********************************************
    // conversion scheduling
    // ***********************************************
    logic [35:0] conv_cnt;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            conv_cnt <= CNT_ZERO;
            CONV_START <= 1'b0;
        end else begin
            CONV_START <= 1'b0;
            if (vcc_rise | I2C_ADDR_VALID) begin
                conv_cnt <= CONV_PERIOD_CNT - FIRST_CONV_CNT;
            end else if (OSC_RUN) begin
                if (conv_cnt >= CONV_PERIOD_CNT - CNT_ONE) begin
                    conv_cnt <= CNT_ZERO;
                    CONV_START <= 1'b1;
                end else begin
                    conv_cnt <= conv_cnt + CNT_ONE;
                end
            end
        end
    end

    // ***********************************************
    // load setting update
    // ***********************************************
    logic [TEMP_W-1:0] last_temp;
    logic signed [9:0] cap_sum;
    logic [7:0] cap_next;

    always_comb begin
        cap_sum = $signed({2'b00, LUT[TEMP_VALUE[LUT_IDX_HI:LUT_IDX_LO]]}) + 10'(AGING_OFFSET);
        if (cap_sum < CAP_MIN) begin
            cap_next = CAP_MIN[7:0];
        end else if (cap_sum > CAP_MAX) begin
            cap_next = CAP_MAX[7:0];
        end else begin
            cap_next = cap_sum[7:0];
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CAP_SEL <= CAP_RESET;
            last_temp <= '0;
        end else if (TEMP_DONE) begin
            last_temp <= TEMP_VALUE;
            if (TEMP_USER || TEMP_VALUE != last_temp) begin
                CAP_SEL <= cap_next;
            end
        end
    end

    // ***********************************************
    // calendar initialisation
    // ***********************************************
    logic cal_inited;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cal_inited <= 1'b0;
            CAL_LOAD <= 1'b0;
            CAL_SECONDS <= INIT_SECONDS;
            CAL_MINUTES <= INIT_MINUTES;
            CAL_HOURS <= INIT_HOURS;
            CAL_WEEKDAY <= INIT_WEEKDAY;
            CAL_DATE <= INIT_DATE;
            CAL_MONTH <= INIT_MONTH;
            CAL_YEAR <= INIT_YEAR;
        end else begin
            CAL_LOAD <= 1'b0;
            if (~cal_inited && (vcc_rise || (I2C_ADDR_VALID && SUPPLY_BAT))) begin
                cal_inited <= 1'b1;
                CAL_LOAD <= 1'b1;
                CAL_SECONDS <= INIT_SECONDS;
                CAL_MINUTES <= INIT_MINUTES;
                CAL_HOURS <= INIT_HOURS;
                CAL_WEEKDAY <= INIT_WEEKDAY;
                CAL_DATE <= INIT_DATE;
                CAL_MONTH <= INIT_MONTH;
                CAL_YEAR <= INIT_YEAR;
            end
        end
    end
endmodule // rprs_top

// *** tb/rprs_properties.sv ***
// port checker of the supply and reset sequencer
// assumes binding to rprs_top with one clock domain
`timescale 1ns/1ns
module rprs_properties (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic VCC_ABOVE_PF,
    input wire logic VCC_ABOVE_BAT,
    input wire logic RSTN_PIN_IN,
    input wire logic RSTN_PIN_OE,
    input wire logic OSC_DISABLE,
    input wire logic CLKOUT_EN,
    input wire logic OSC_CLK_OE,
    input wire logic OSC_RUN,
    input wire logic SUPPLY_BAT,
    input wire logic CONV_START,
    input wire logic TEMP_DONE,
    input wire logic [7:0] CAP_SEL,
    input wire logic CAL_LOAD,
    input wire logic [7:0] CAL_SECONDS,
    input wire logic [7:0] CAL_MINUTES,
    input wire logic [7:0] CAL_HOURS,
    input wire logic [7:0] CAL_WEEKDAY,
    input wire logic [7:0] CAL_DATE,
    input wire logic [7:0] CAL_MONTH,
    input wire logic [7:0] CAL_YEAR
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic cal_done;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) cal_done <= 1'b0;
        else if (CAL_LOAD) cal_done <= 1'b1;
    end
    // ***********************************************
    // assertions
    // ***********************************************
    sequence s_vcc_back; !VCC_ABOVE_PF ##1 VCC_ABOVE_PF; endsequence
    sequence s_press; VCC_ABOVE_PF [*6] ##0 ($fell(RSTN_PIN_IN) && !RSTN_PIN_OE); endsequence
    property p_fail_low; !VCC_ABOVE_PF [*6] |-> RSTN_PIN_OE; endproperty
    a_fail_low: assert property (p_fail_low) else $error("reset wire free on supply fail");
    property p_recover; s_vcc_back ##0 OSC_RUN ##1 (VCC_ABOVE_PF && !OSC_DISABLE) [*8] |-> RSTN_PIN_OE; endproperty
    a_recover: assert property (p_recover) else $error("recovery delay cut short");
    property p_fast; s_vcc_back ##1 (VCC_ABOVE_PF && OSC_DISABLE) [*8] |-> !RSTN_PIN_OE; endproperty
    a_fast: assert property (p_fast) else $error("reset held with oscillator off");
    property p_press; s_press |-> ##[3:5] RSTN_PIN_OE; endproperty
    a_press: assert property (p_press) else $error("pushbutton not answered");
    property p_main_sel; (VCC_ABOVE_PF || VCC_ABOVE_BAT) [*5] |-> !SUPPLY_BAT; endproperty
    a_main_sel: assert property (p_main_sel) else $error("battery chosen with main good");
    property p_osc_off; OSC_DISABLE [*2] |-> !OSC_RUN; endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator runs while disabled");
    property p_conv; CONV_START |-> $past(OSC_RUN) ##1 !CONV_START; endproperty
    a_conv: assert property (p_conv) else $error("bad conversion start");
    property p_cap; $changed(CAP_SEL) |-> $past(TEMP_DONE); endproperty
    a_cap: assert property (p_cap) else $error("load setting changed without conversion");
    property p_cal; CAL_LOAD |-> !cal_done && {CAL_SECONDS, CAL_MINUTES, CAL_HOURS, CAL_WEEKDAY,
        CAL_DATE, CAL_MONTH, CAL_YEAR} == 56'h00000001010100; endproperty
    a_cal: assert property (p_cal) else $error("calendar start values wrong");
    property p_clk_gate; (!CLKOUT_EN || !OSC_RUN) [*3] |-> !OSC_CLK_OE; endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock output while stopped");
endmodule // rprs_properties
bind rprs_top rprs_properties u_rprs_properties (.CLK_SYS, .RST, .VCC_ABOVE_PF, .VCC_ABOVE_BAT,
    .RSTN_PIN_IN, .RSTN_PIN_OE, .OSC_DISABLE, .CLKOUT_EN, .OSC_CLK_OE, .OSC_RUN, .SUPPLY_BAT,
    .CONV_START, .TEMP_DONE, .CAP_SEL, .CAL_LOAD, .CAL_SECONDS, .CAL_MINUTES, .CAL_HOURS,
    .CAL_WEEKDAY, .CAL_DATE, .CAL_MONTH, .CAL_YEAR);

// *** tb/rprs_host_model.sv ***
// host side: reset wire with pull-up, pushbutton, serial address pulse
// assumes press and addr_req change at the clock edge
`timescale 1ns/1ns
module rprs_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic press,
    input wire logic addr_req,
    input wire logic rstn_oe,
    output logic rstn_wire,
    output logic addr_valid
);
    logic addr_q;
    // pulled up unless a party pulls it low
    assign rstn_wire = !(rstn_oe || press);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 1'b0;
            addr_valid <= 1'b0;
        end else begin
            addr_q <= addr_req;
            addr_valid <= addr_req && !addr_q;
        end
    end
endmodule // rprs_host_model

// *** tb/test_rprs_top.sv ***
// self-checking bench of the supply and reset sequencer
// assumes shortened timers and the host model on the reset wire
`timescale 1ns/1ns
module test_rprs_top;
    logic CLK_SYS, RST, VCC_ABOVE_PF, VCC_ABOVE_BAT, BAT_PRESENT, OSC_DISABLE, CLKOUT_EN;
    logic TEMP_DONE, TEMP_USER, press, addr_req, oe_q, cal_seen, RSTN_PIN_IN, RSTN_PIN_OE;
    logic I2C_ADDR_VALID, OSC_CLK_OE, OSC_RUN, SUPPLY_BAT, CONV_START, CAL_LOAD;
    logic [2:0] osc_div;
    logic [9:0] TEMP_VALUE;
    logic signed [7:0] AGING_OFFSET;
    logic [7:0] CAP_SEL;
    int fails, comparisons, n, clk_rises;
    rprs_top #(.DEBOUNCE_CNT(36'h14), .HOLD_CNT(36'h14), .RECOVERY_CNT(36'h14), .FIRST_CONV_CNT(36'hA),
        .CONV_PERIOD_CNT(36'h32)) u_rprs_top (.CLK_SYS, .RST, .VCC_ABOVE_PF, .VCC_ABOVE_BAT,
        .BAT_PRESENT, .RSTN_PIN_IN, .RSTN_PIN_OUT(), .RSTN_PIN_OE, .OSC_DISABLE, .I2C_ADDR_VALID,
        .OSC_CLK_IN(osc_div[2]), .CLKOUT_EN, .OSC_CLK_OUT(), .OSC_CLK_OE, .OSC_RUN, .SUPPLY_BAT,
        .CONV_START, .TEMP_DONE, .TEMP_USER, .TEMP_VALUE, .AGING_OFFSET, .CAP_SEL, .CAL_LOAD,
        .CAL_SECONDS(), .CAL_MINUTES(), .CAL_HOURS(), .CAL_WEEKDAY(), .CAL_DATE(), .CAL_MONTH(),
        .CAL_YEAR());
    rprs_host_model u_rprs_host_model (.clk(CLK_SYS), .rst(RST), .press, .addr_req,
        .rstn_oe(RSTN_PIN_OE), .rstn_wire(RSTN_PIN_IN), .addr_valid(I2C_ADDR_VALID));
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        osc_div <= osc_div + 3'h1;
        oe_q <= OSC_CLK_OE;
        if (CAL_LOAD === 1'b1) cal_seen <= 1'b1;
        if (OSC_CLK_OE === 1'b1 && oe_q !== 1'b1) clk_rises <= clk_rises + 1;
    end
    task chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wait_lvl(ref logic s, input logic v, output int k);
        for (k = 0; k < 200 && s !== v; k++) cyc(1);
    endtask
    task temp(input logic [9:0] v, input logic [7:0] a, input logic u);
        @(posedge CLK_SYS) {TEMP_VALUE, AGING_OFFSET, TEMP_USER, TEMP_DONE} <= {v, a, u, 1'b1};
        @(posedge CLK_SYS) TEMP_DONE <= 1'b0;
        cyc(1);
    endtask
    // ***********************************************
    // scenarios
    // ***********************************************
    task t_battery;
        cyc(20);
        chk("osc_run", 0, OSC_RUN);
        chk("supply_bat", 1, SUPPLY_BAT);
        chk("rst_oe", 1, RSTN_PIN_OE);
        @(posedge CLK_SYS) addr_req <= 1'b1;
        wait_lvl(CONV_START, 1'b1, n);
        chk("first_conv", 1, n > 5 && n < 25);
        chk("cal_load", 1, cal_seen);
        chk("clk_out", 1, clk_rises > 1);
        @(posedge CLK_SYS) VCC_ABOVE_PF <= 1'b1;
        cyc(12);
        chk("recover", 1, RSTN_PIN_OE);
        chk("supply_main", 0, SUPPLY_BAT);
        wait_lvl(RSTN_PIN_OE, 1'b0, n);
        chk("release", 1, n > 5 && n < 20);
        wait_lvl(CONV_START, 1'b1, n);
        cyc(1);
        wait_lvl(CONV_START, 1'b1, n);
        chk("conv_period", 36'h31, n);
    endtask
    task t_fail;
        @(posedge CLK_SYS) VCC_ABOVE_PF <= 1'b0;
        cyc(8);
        chk("fail_oe", 1, RSTN_PIN_OE);
        chk("fail_bat", 1, SUPPLY_BAT);
        chk("osc_bat", 1, OSC_RUN);
        @(posedge CLK_SYS) VCC_ABOVE_BAT <= 1'b1;
        cyc(8);
        chk("above_bat", 0, SUPPLY_BAT);
        @(posedge CLK_SYS) {VCC_ABOVE_BAT, VCC_ABOVE_PF} <= 2'h1;
        wait_lvl(RSTN_PIN_OE, 1'b0, n);
        chk("recover_len", 1, n > 18 && n < 28);
    endtask
    task t_osc_disable;
        @(posedge CLK_SYS) OSC_DISABLE <= 1'b1;
        cyc(3);
        chk("osc_stop", 0, OSC_RUN);
        @(posedge CLK_SYS) VCC_ABOVE_PF <= 1'b0;
        cyc(8);
        @(posedge CLK_SYS) VCC_ABOVE_PF <= 1'b1;
        wait_lvl(RSTN_PIN_OE, 1'b0, n);
        chk("fast_release", 1, n < 8);
        @(posedge CLK_SYS) OSC_DISABLE <= 1'b0;
        cyc(3);
        chk("osc_again", 1, OSC_RUN);
    endtask
    task t_press;
        @(posedge CLK_SYS) press <= 1'b1;
        cyc(10);
        chk("debounce", 1, RSTN_PIN_OE);
        cyc(20);
        chk("wait_rel", 0, RSTN_PIN_OE);
        chk("osc_kept", 1, OSC_RUN);
        @(posedge CLK_SYS) press <= 1'b0;
        cyc(10);
        chk("hold", 1, RSTN_PIN_OE);
        wait_lvl(RSTN_PIN_OE, 1'b0, n);
        chk("hold_len", 1, n > 5 && n < 20);
    endtask
    task t_cap;
        temp(10'h100, 8'h03, 1'b0);
        chk("cap_lut", 8'h6B, CAP_SEL);
        temp(10'h100, 8'h05, 1'b0);
        chk("cap_same", 8'h6B, CAP_SEL);
        temp(10'h100, 8'h05, 1'b1);
        chk("cap_user", 8'h6D, CAP_SEL);
        temp(10'h000, 8'h80, 1'b0);
        chk("cap_clamp", 8'h00, CAP_SEL);
    endtask
    task t_reinit;
        @(posedge CLK_SYS) {RST, addr_req} <= 2'h2;
        cyc(3);
        @(posedge CLK_SYS) {RST, cal_seen} <= 2'h0;
        wait_lvl(OSC_RUN, 1'b1, n);
        chk("vcc_start", 1, n < 8);
        chk("cal_vcc", 1, cal_seen);
        chk("no_recovery", 0, RSTN_PIN_OE);
        chk("vcc_main", 0, SUPPLY_BAT);
    endtask
    task end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {RST, BAT_PRESENT, CLKOUT_EN, VCC_ABOVE_PF, VCC_ABOVE_BAT, OSC_DISABLE} = 6'h38;
        {TEMP_DONE, TEMP_USER, press, addr_req, oe_q, cal_seen, osc_div} = 9'h0;
        {TEMP_VALUE, AGING_OFFSET, fails, comparisons, clk_rises} = '0;
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_battery;
        t_fail;
        t_osc_disable;
        t_press;
        t_cap;
        t_reinit;
        end_sim;
    end
    initial begin
        #20000;
        fails++;
        end_sim;
    end
endmodule // test_rprs_top
